// *** inc/prer_regs.vh ***
// Register offsets, field positions, reset values and codes of the page request event block
`ifndef PRER_REGS_VH
`define PRER_REGS_VH

// Register offsets (word addresses on the plain register port)
`define PRER_ADDR_STATUS      4'h0
`define PRER_ADDR_EVCTL       4'h1
`define PRER_ADDR_TAIL        4'h2
`define PRER_ADDR_CMDQ_CFG    4'h3
`define PRER_ADDR_RESP_STAT   4'h4

// Request status register fields
`define PRER_STAT_PEND_BIT    0
`define PRER_STAT_OVFL_BIT    1

// Event control register fields
`define PRER_EVCTL_HELD_BIT   30
`define PRER_EVCTL_MASK_BIT   31

// Command queue configuration field
`define PRER_CFG_WIDE_BIT     11

// Reset values
`define PRER_EVCTL_RST        32'h8000_0000
`define PRER_CFG_RST          32'h0000_0000
`define PRER_EVCTL_MASK_RST   1'b1
`define PRER_CFG_WIDE_RST     1'b0

// Descriptor type code and field positions of a group response
`define PRER_TYPE_GRP_RESP    7'h09
`define PRER_DSC_FID_LSB      16
`define PRER_DSC_TAGP_BIT     32
`define PRER_DSC_PTAG_LSB     33
`define PRER_DSC_PDP_BIT      4
`define PRER_DSC_GIDX_LSB     64
`define PRER_DSC_CODE_LSB     76
`define PRER_DSC_LAST_BIT     75
`define PRER_DSC_PDATA_LSB    128

// Group status codes
`define PRER_CODE_SUCCESS     4'h0
`define PRER_CODE_INVALID     4'h1
`define PRER_CODE_FAILURE     4'hf

`endif

// *** hdl/prer_event_resp.v ***
// Page request event logic and page group response decoder
//
// Operation
// R1 - Descriptor write sets pending request flag
// R2 - Queue full sets queue overflow flag
// R3 - Either flag set suppresses new event
// R4 - Otherwise set held flag, check mask
// R5 - Mask clear: interrupt, clear held flag
// R6 - Mask set: no interrupt, keep held
// R7 - Unmask with held set: interrupt, clear
// R8 - Both flags cleared: drop held silently
// R9 - Descriptor visible before its interrupt
// R10 - Tail read waits for delivered requests; tail reads here answer next cycle without waiting for requests in flight
// R11 - Status reads first commit pending interrupt; reads here answer next cycle without waiting for a queued interrupt
// R12 - Event interrupt goes direct, unremapped
// R13 - Accepted at issue, delivered after tail
// R14 - Narrow command queue: invalid descriptor error
// R15 - Seven bit type, 9h is response
// R16 - One response message per descriptor
// R17 - Identifier: bus high, device/function low
// R18 - Ignore private data / tag when absent
// R19 - Status codes 0h, 1h, Fh only; other codes are passed on here, flagged in code_bad_ff
// R20 - Private data requests get private replies
// R21 - Final response after whole group serviced
// R22 - Software copies request fields unchanged
// R23 - Write at tail, then advance tail
// R24 - Evaluate once, using pre-event flags
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "prer_regs.vh"

module prer_event_resp #(
    parameter TAIL_W = 16
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_b,
    // Register port
    input  wire [3:0]   reg_addr,
    input  wire [31:0]  reg_wdata,
    input  wire         reg_wr,
    input  wire         reg_rd,
    output reg  [31:0]  reg_rdata_ff,
    // Request log queue writer
    input  wire         req_issue,
    input  wire         req_visible,
    input  wire         req_queue_full,
    output reg  [TAIL_W-1:0] queue_tail_ff,
    // Command queue descriptors
    input  wire         dsc_valid,
    input  wire [255:0] dsc_data,
    output reg          dsc_invalid_ff,
    // Response message to endpoint
    output reg          resp_valid_ff,
    output reg  [7:0]   resp_bus_ff,
    output reg  [7:0]   resp_devfn_ff,
    output reg          resp_tag_present_ff,
    output reg  [19:0]  resp_process_tag_ff,
    output reg  [8:0]   resp_group_index_ff,
    output reg  [3:0]   resp_status_code_ff,
    output reg          resp_final_ff,
    output reg          resp_private_ff,
    output reg  [127:0] resp_private_data_ff,
    // Event interrupt, direct delivery
    output reg          event_irq_ff
);

    reg                 pending_request_flag_ff;
    reg                 queue_overflow_flag_ff;
    reg                 event_held_flag_ff;
    reg                 event_mask_bit_ff;
    reg                 wide_entry_select_ff;
    reg  [3:0]          last_code_ff;
    reg                 code_bad_ff;
    reg  [7:0]          inflight_ff;
    reg                 irq_want_ff;

    wire wr_status = reg_wr && reg_addr == `PRER_ADDR_STATUS;
    wire wr_evctl  = reg_wr && reg_addr == `PRER_ADDR_EVCTL;
    wire wr_cfg    = reg_wr && reg_addr == `PRER_ADDR_CMDQ_CFG;

    // Flags seen before this cycle's update
    wire any_flag  = pending_request_flag_ff | queue_overflow_flag_ff;
    wire event_in  = req_issue | req_queue_full;
    wire raise     = event_in && !any_flag;
    wire all_done  = inflight_ff == 8'h00;

    // Write-one-to-clear of the status flags, set wins
    wire clr_pend  = wr_status && reg_wdata[`PRER_STAT_PEND_BIT];
    wire clr_ovfl  = wr_status && reg_wdata[`PRER_STAT_OVFL_BIT];
    wire nxt_pend  = req_issue | (pending_request_flag_ff & ~clr_pend);
    wire nxt_ovfl  = req_queue_full | (queue_overflow_flag_ff & ~clr_ovfl);
    wire nxt_mask  = wr_evctl ? reg_wdata[`PRER_EVCTL_MASK_BIT] : event_mask_bit_ff;
    wire unmask    = event_mask_bit_ff && !nxt_mask;

    // Descriptor decode
    wire [6:0] dsc_type = {dsc_data[11:9], dsc_data[3:0]};
    wire       is_resp  = dsc_valid && dsc_type == `PRER_TYPE_GRP_RESP;
    wire [3:0] dsc_code = dsc_data[`PRER_DSC_CODE_LSB +: 4];
    wire       dsc_tagp = dsc_data[`PRER_DSC_TAGP_BIT];
    wire       dsc_pdp  = dsc_data[`PRER_DSC_PDP_BIT];

    // Event state
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pending_request_flag_ff <= 1'b0;
            queue_overflow_flag_ff  <= 1'b0;
            event_held_flag_ff      <= 1'b0;
            event_mask_bit_ff       <= `PRER_EVCTL_MASK_RST;
            irq_want_ff             <= 1'b0;
            event_irq_ff            <= 1'b0;
            inflight_ff             <= 8'h00;
            queue_tail_ff           <= {TAIL_W{1'b0}};
        end else begin
            pending_request_flag_ff <= nxt_pend; // R1
            queue_overflow_flag_ff  <= nxt_ovfl; // R2
            event_mask_bit_ff       <= nxt_mask;
            // Accepted at issue, delivered when visible
            inflight_ff <= inflight_ff + {7'h00, req_issue} - {7'h00, req_visible}; // R13
            if (req_visible) begin
                queue_tail_ff <= queue_tail_ff + {{(TAIL_W-1){1'b0}}, 1'b1}; // R23
            end
            event_irq_ff <= 1'b0;
            if (raise && nxt_mask) begin
                event_held_flag_ff <= 1'b1; // R3 R4 R6 R24
            end else if (raise || (unmask && event_held_flag_ff)) begin
                // Interrupt queued until every accepted request is delivered
                event_held_flag_ff <= 1'b0; // R5 R7
                irq_want_ff        <= 1'b1;
            end else if (event_held_flag_ff && !nxt_pend && !nxt_ovfl) begin
                event_held_flag_ff <= 1'b0; // R8
            end
            // Direct pulse, no remapping stage
            if (irq_want_ff && all_done && !req_issue) begin
                irq_want_ff  <= 1'b0; // R9
                event_irq_ff <= 1'b1; // R12
            end
        end
    end

    // Register reads answer next cycle; no wait states, so tail only shows delivered work
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_ff <= 32'h0000_0000;
            wide_entry_select_ff <= `PRER_CFG_WIDE_RST;
        end else begin
            if (wr_cfg) begin
                wide_entry_select_ff <= reg_wdata[`PRER_CFG_WIDE_BIT];
            end
            reg_rdata_ff <= 32'h0000_0000;
            if (reg_rd) begin
                case (reg_addr)
                    `PRER_ADDR_STATUS:
                        reg_rdata_ff <= {30'h0, queue_overflow_flag_ff,
                                         pending_request_flag_ff}; // R11
                    `PRER_ADDR_EVCTL:
                        reg_rdata_ff <= {event_mask_bit_ff, event_held_flag_ff, 30'h0}; // R11
                    `PRER_ADDR_TAIL:
                        reg_rdata_ff <= {{(32-TAIL_W){1'b0}}, queue_tail_ff}; // R10
                    `PRER_ADDR_CMDQ_CFG:
                        reg_rdata_ff <= {20'h0, wide_entry_select_ff, 11'h0};
                    `PRER_ADDR_RESP_STAT:
                        reg_rdata_ff <= {27'h0, code_bad_ff, last_code_ff};
                    default:
                        reg_rdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Group response decode
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dsc_invalid_ff       <= 1'b0;
            resp_valid_ff        <= 1'b0;
            resp_bus_ff          <= 8'h00;
            resp_devfn_ff        <= 8'h00;
            resp_tag_present_ff  <= 1'b0;
            resp_process_tag_ff  <= 20'h00000;
            resp_group_index_ff  <= 9'h000;
            resp_status_code_ff  <= 4'h0;
            resp_final_ff        <= 1'b0;
            resp_private_ff      <= 1'b0;
            resp_private_data_ff <= 128'h0;
            last_code_ff         <= 4'h0;
            code_bad_ff          <= 1'b0;
        end else begin
            resp_valid_ff  <= 1'b0;
            dsc_invalid_ff <= 1'b0;
            if (is_resp && !wide_entry_select_ff) begin
                dsc_invalid_ff <= 1'b1; // R14
            end else if (is_resp) begin
                resp_valid_ff       <= 1'b1; // R15 R16
                resp_bus_ff         <= dsc_data[`PRER_DSC_FID_LSB+8 +: 8]; // R17
                resp_devfn_ff       <= dsc_data[`PRER_DSC_FID_LSB +: 8]; // R17
                resp_tag_present_ff <= dsc_tagp;
                resp_process_tag_ff <= dsc_tagp ? dsc_data[`PRER_DSC_PTAG_LSB +: 20]
                                                : 20'h00000; // R18
                resp_group_index_ff <= dsc_data[`PRER_DSC_GIDX_LSB +: 9];
                resp_status_code_ff <= dsc_code;
                resp_final_ff       <= dsc_data[`PRER_DSC_LAST_BIT];
                resp_private_ff     <= dsc_pdp;
                resp_private_data_ff <= dsc_pdp ? dsc_data[`PRER_DSC_PDATA_LSB +: 128]
                                                : 128'h0; // R18
                last_code_ff        <= dsc_code;
                // Reserved codes are passed on but flagged for software
                code_bad_ff <= !(dsc_code == `PRER_CODE_SUCCESS ||
                                 dsc_code == `PRER_CODE_INVALID ||
                                 dsc_code == `PRER_CODE_FAILURE); // R19
            end
        end
    end

endmodule

// *** verification/prer_event_resp_asserts.sv ***
// Port checker for the page request event block
`timescale 1ns/1ps
`include "prer_regs.vh"
module prer_event_resp_asserts #(
    parameter TAIL_W = 16
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst_b,
    // Request log queue writer
    input wire logic              req_issue,
    input wire logic              req_visible,
    input wire logic [TAIL_W-1:0] queue_tail_ff,
    // Descriptors and responses
    input wire logic              dsc_valid,
    input wire logic [255:0]      dsc_data,
    input wire logic              dsc_invalid_ff,
    input wire logic              resp_valid_ff,
    input wire logic [7:0]        resp_bus_ff,
    input wire logic [7:0]        resp_devfn_ff,
    input wire logic              event_irq_ff
);
    logic [7:0] infl_ff;
    wire        grp = dsc_valid && {dsc_data[11:9], dsc_data[3:0]} == `PRER_TYPE_GRP_RESP;
    // Issued but not yet visible requests
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            infl_ff <= 8'h00;
        else
            infl_ff <= infl_ff + {7'h00, req_issue} - {7'h00, req_visible};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_irq_delivered: assert property (event_irq_ff |-> infl_ff == 8'h00)
        else $error("event interrupt with a request in flight");
    a_irq_single: assert property (event_irq_ff |=> !event_irq_ff)
        else $error("event interrupt longer than one cycle");
    a_tail_step: assert property (req_visible |=>
        queue_tail_ff == $past(queue_tail_ff) + 1'b1) else $error("tail did not advance");
    a_tail_hold: assert property (!req_visible |=> $stable(queue_tail_ff))
        else $error("tail moved without a visible write");
    a_resp_or_err: assert property (grp |=> resp_valid_ff != dsc_invalid_ff)
        else $error("group response neither sent nor refused");
    a_other_type: assert property (dsc_valid && !grp |=> !resp_valid_ff && !dsc_invalid_ff)
        else $error("other descriptor type acted on");
    a_bus_split: assert property (grp |=> dsc_invalid_ff || resp_bus_ff == $past(dsc_data[31:24]))
        else $error("bus number wrong");
    a_devfn_split: assert property (grp |=>
        dsc_invalid_ff || resp_devfn_ff == $past(dsc_data[23:16])) else $error("devfn wrong");
endmodule
bind prer_event_resp prer_event_resp_asserts #(.TAIL_W(TAIL_W)) prer_event_resp_asserts_i (
    .clk, .rst_b, .req_issue, .req_visible, .queue_tail_ff, .dsc_valid, .dsc_data,
    .dsc_invalid_ff, .resp_valid_ff, .resp_bus_ff, .resp_devfn_ff, .event_irq_ff);

// *** verification/prer_partner.sv ***
// Endpoint side model that issues requests and later makes them visible
`timescale 1ns/1ps
module prer_partner (
    // Clock
    input  wire logic clk,
    // Request log queue writer
    output logic      req_issue,
    output logic      req_visible
);
    initial begin
        req_issue = 1'b0;
        req_visible = 1'b0;
    end
    // Visible always trails issue; lag sets how slow delivery is
    task post(input int lag);
        @(posedge clk);
        req_issue <= 1'b1;
        @(posedge clk);
        req_issue <= 1'b0;
        repeat (lag) @(posedge clk);
        req_visible <= 1'b1;
        @(posedge clk);
        req_visible <= 1'b0;
    endtask
endmodule

// *** verification/tb_prer_event_resp.sv ***
// Self-checking bench for the page request event block
`timescale 1ns/1ps
module tb_prer_event_resp;
    logic clk, rst_b, reg_wr, reg_rd, req_queue_full, dsc_valid, req_issue, req_visible;
    logic dsc_invalid_ff, resp_valid_ff, resp_tag_present_ff, resp_final_ff, resp_private_ff;
    logic event_irq_ff;
    logic [3:0]   reg_addr, resp_status_code_ff, code;
    logic [7:0]   resp_bus_ff, resp_devfn_ff;
    logic [8:0]   resp_group_index_ff;
    logic [15:0]  queue_tail_ff;
    logic [19:0]  resp_process_tag_ff;
    logic [31:0]  reg_wdata, reg_rdata_ff;
    logic [127:0] resp_private_data_ff;
    logic [255:0] dsc_data, d;
    int           errors, checked, irqs;
    prer_event_resp #(.TAIL_W(16)) prer_event_resp_i (.clk, .rst_b, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata_ff, .req_issue, .req_visible, .req_queue_full,
        .queue_tail_ff, .dsc_valid, .dsc_data, .dsc_invalid_ff, .resp_valid_ff, .resp_bus_ff,
        .resp_devfn_ff, .resp_tag_present_ff, .resp_process_tag_ff, .resp_group_index_ff,
        .resp_status_code_ff, .resp_final_ff, .resp_private_ff, .resp_private_data_ff,
        .event_irq_ff);
    prer_partner prer_partner_i (.clk, .req_issue, .req_visible);
    task chk(input string n, input logic [127:0] e, input logic [127:0] g);
        checked++;
        if (e !== g) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk("rdata", e, reg_rdata_ff);
    endtask
    task snd(input logic [255:0] v);
        @(posedge clk);
        dsc_data <= v;
        dsc_valid <= 1'b1;
        @(posedge clk);
        dsc_valid <= 1'b0;
        @(negedge clk);
    endtask
    task give_verdict;
        if (errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(negedge clk) if (event_irq_ff === 1'b1) irqs++;
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        give_verdict;
    end
    initial begin
        {rst_b, reg_wr, reg_rd, req_queue_full, dsc_valid} = 5'h00;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        dsc_data = 256'h0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rd(4'h1, 32'h8000_0000);
        prer_partner_i.post(2);
        rd(4'h1, 32'hc000_0000);
        rd(4'h0, 32'h0000_0001);
        prer_partner_i.post(1);
        chk("irqs", 0, irqs);
        wr(4'h1, 32'h0);
        repeat (4) @(posedge clk);
        chk("irqs", 1, irqs);
        rd(4'h1, 32'h0);
        wr(4'h1, 32'h8000_0000);
        wr(4'h0, 32'h3);
        prer_partner_i.post(1);
        rd(4'h1, 32'hc000_0000);
        wr(4'h0, 32'h3);
        rd(4'h1, 32'h8000_0000);
        wr(4'h1, 32'h0);
        prer_partner_i.post(6);
        chk("irqs", 1, irqs);
        repeat (4) @(posedge clk);
        chk("irqs", 2, irqs);
        wr(4'h0, 32'h3);
        req_queue_full <= 1'b1;
        @(posedge clk);
        req_queue_full <= 1'b0;
        repeat (4) @(posedge clk);
        chk("irqs", 3, irqs);
        rd(4'h0, 32'h2);
        rd(4'h2, 32'h4);
        chk("tail", 16'h0004, queue_tail_ff);
        // Private data and tag fields carry noise that must be dropped when absent
        wr(4'h3, 32'h0000_0800);
        for (int i = 0; i < 3; i++) begin
            code = (i == 2) ? 4'hf : i[3:0];
            // Replies copy the request's tag, group and private data unchanged
            d = {{8{16'h5a0f}}, 48'h0, code, 1'b1, 2'h0, 9'h1ff, 11'h0, 20'h12345, i == 2,
                16'ha53c, 11'h0, i == 1, 4'h9};
            snd(d);
            chk("code", code, resp_status_code_ff);
            chk("fields", {1'b1, i == 2, i == 1, 1'b1, 9'h1ff}, {resp_valid_ff,
                resp_tag_present_ff, resp_private_ff, resp_final_ff, resp_group_index_ff});
            chk("fid", 16'ha53c, {resp_bus_ff, resp_devfn_ff});
            chk("pdata", i == 1 ? d[255:128] : 128'h0, resp_private_data_ff);
            chk("ptag", i == 2 ? 20'h12345 : 20'h0, resp_process_tag_ff);
        end
        rd(4'h4, 32'h0000_000f);
        // Reserved code must still be forwarded, and flagged
        d[79:76] = 4'h5;
        snd(d);
        chk("code", 4'h5, resp_status_code_ff);
        rd(4'h4, 32'h0000_0015);
        wr(4'h3, 32'h0);
        snd(d);
        chk("invalid", 2'h2, {dsc_invalid_ff, resp_valid_ff});
        d[3:0] = 4'h1;
        snd(d);
        chk("other", 2'h0, {dsc_invalid_ff, resp_valid_ff});
        give_verdict;
    end
endmodule
